/* inc/ioc_consts.vh */
// Constants for the interrupt and oscillator control block
// Behaviour
// - Fixed priority ext0, ext1, t0, t1, serial, multi
// - Vectors 04, 08, 0C, 10, 14, 18 hex
// - Secondary: enables bits 0-2, flags 4-6
// - Multi-function: enables bits 0-2, flags 4-6
// - Primary register at 0BH holds master/ext/timer0
// - Secondary register decoded at address 1EH
// - Multi-function register decoded at address 2FH
// - Cleared primary/secondary enable blocks servicing of its request; multi-function enables gate nothing
// - Primary/secondary flags stay set until serviced/cleared
// - Timer2, clock, tick flags cleared only by software
// - Clock source chosen among RC, crystal, 32768Hz
// - RC/crystal power-down stops oscillator, ignores inputs
// - 32768Hz power-down keeps oscillator, halts execution
// - 32768Hz power-down keeps RTC/tick/watchdog timing
// - RC mode drives clock divided by four out
// - Clock oscillator fixed 32.768kHz on own pins
// - Quick start bit 4; software clears after 2s
// - Watchdog oscillator free running through power-down
// - Option disables watchdog oscillator entirely
// - Vectoring clears master enable; return-from-irq sets it
// - No acknowledge while call stack is full
// - Vectoring clears only the granted source's flag (ext0, ext1, timer0, timer1, serial or summary)
// - Any multi source flag sets summary flag
`ifndef IOC_CONSTS_VH
`define IOC_CONSTS_VH
`define IOC_OFS_PRIMARY 8'h2C
`define IOC_OFS_SECONDARY 8'h78
`define IOC_OFS_MULTI 8'hBC
`define IOC_OFS_CLKCTL 8'hC0
`define IOC_OFS_STATUS 8'hC4
`define IOC_IDX_PRIMARY 8'h0B
`define IOC_IDX_SECONDARY 8'h1E
`define IOC_IDX_MULTI 8'h2F
`define IOC_RESET_BYTE 8'h00
`define IOC_BIT_MASTER 0
`define IOC_BIT_QUICK 4
`define IOC_VEC_EXT0 8'h04
`define IOC_VEC_EXT1 8'h08
`define IOC_VEC_T0 8'h0C
`define IOC_VEC_T1 8'h10
`define IOC_VEC_SERIAL 8'h14
`define IOC_VEC_MULTI 8'h18
`define IOC_SRC_RC 2'h0
`define IOC_SRC_XTAL 2'h1
`define IOC_SRC_32K 2'h2
`define IOC_RESP_OK 2'h0
`define IOC_RESP_SLVERR 2'h2
`endif

/* design/ioc_irq_osc_ctrl.v */
// Interrupt controller with oscillator and power-down clock control
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.vh"
module ioc_irq_osc_ctrl #(
	parameter CLK_SEL_DEFAULT = 2'h0
) (
	input wire clock,
	input wire rst_b,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext0_event,
	input wire ext1_event,
	input wire timer0_event,
	input wire timer1_event,
	input wire serial_event,
	input wire timer2_event,
	input wire tick_event,
	input wire clock_timeout_event,
	input wire [1:0] clk_source_sel,
	input wire wdt_osc_disable,
	input wire power_down,
	input wire stack_full,
	input wire instr_boundary,
	input wire return_from_irq,
	output reg irq_vector_valid,
	output reg [7:0] irq_vector,
	output reg sys_osc_enable,
	output reg exec_halt,
	output reg ext_inputs_gate,
	output reg timing_run,
	output reg clock_osc_enable,
	output reg clock_osc_quick,
	output reg wdt_osc_enable,
	output reg osc_out_pin,
	output reg osc_out_pin_oe
);
	reg [6:0] pri_reg;
	reg [6:0] pri_next;
	reg [6:0] sec_reg;
	reg [6:0] sec_next;
	reg [6:0] mf_reg;
	reg [6:0] mf_next;
	reg quick_reg;
	reg [1:0] div_reg;
	reg [1:0] src_reg;
	reg wr_aw_reg;
	reg wr_w_reg;
	reg [7:0] wr_addr_reg;
	reg [7:0] wr_data_reg;
	reg [7:0] rd_byte;
	reg rd_ok;
	reg [5:0] pend;
	reg [7:0] vec_sel;
	reg [5:0] grant;
	reg take;
	reg [1:0] sy_a;
	reg [1:0] sy_b;
	reg [2:0] sy_c;
	reg [1:0] sel_s1_reg;
	reg [1:0] sel_s2_reg;
	wire [7:0] ev_in;
	reg [7:0] ev_s1_reg;
	reg [7:0] ev_s2_reg;
	reg [7:0] ev_prev_reg;
	wire [7:0] ev_rise;
	wire wr_fire;
	wire pd_s;
	wire wdt_off_s;
	assign ev_in = {clock_timeout_event, tick_event, timer2_event, serial_event,
		timer1_event, timer0_event, ext1_event, ext0_event};
	// Event pins are asynchronous; two stages then an edge detector
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ev_s1_reg <= 8'h00;
			ev_s2_reg <= 8'h00;
			ev_prev_reg <= 8'h00;
			sy_a <= 2'h0;
			sy_b <= 2'h0;
			sy_c <= 3'h0;
			sel_s1_reg <= 2'h0;
			sel_s2_reg <= 2'h0;
		end else begin
			ev_s1_reg <= ev_in;
			ev_s2_reg <= ev_s1_reg;
			ev_prev_reg <= ev_s2_reg;
			sy_a <= {sy_a[0], power_down};
			sy_b <= {sy_b[0], wdt_osc_disable};
			// Marks the first cycles after reset release, long enough for the strap to pass its two stages
			sy_c <= {sy_c[1:0], 1'b1};
			sel_s1_reg <= clk_source_sel;
			sel_s2_reg <= sel_s1_reg;
		end
	end
	assign pd_s = sy_a[1];
	assign wdt_off_s = sy_b[1];
	// Source-select strap is caught after reset release
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			src_reg <= `IOC_SRC_RC;
		else if (!sy_c[2])
			src_reg <= (sel_s2_reg == 2'h3) ? CLK_SEL_DEFAULT[1:0] : sel_s2_reg;
	end
	// External inputs ignored in power-down with RC or crystal source
	assign ev_rise = ev_s2_reg & ~ev_prev_reg &
		((pd_s && src_reg != `IOC_SRC_32K) ? 8'hFC : 8'hFF);
	always @* begin
		pend[0] = pri_reg[4] & pri_reg[1];
		pend[1] = pri_reg[5] & pri_reg[2];
		pend[2] = pri_reg[6] & pri_reg[3];
		pend[3] = sec_reg[4] & sec_reg[0];
		pend[4] = sec_reg[5] & sec_reg[1];
		pend[5] = sec_reg[6] & sec_reg[2];
		take = instr_boundary & pri_reg[`IOC_BIT_MASTER] & ~stack_full & (|pend);
		grant = 6'h00;
		vec_sel = `IOC_VEC_MULTI;
		if (pend[0]) begin
			grant = 6'h01;
			vec_sel = `IOC_VEC_EXT0;
		end else if (pend[1]) begin
			grant = 6'h02;
			vec_sel = `IOC_VEC_EXT1;
		end else if (pend[2]) begin
			grant = 6'h04;
			vec_sel = `IOC_VEC_T0;
		end else if (pend[3]) begin
			grant = 6'h08;
			vec_sel = `IOC_VEC_T1;
		end else if (pend[4]) begin
			grant = 6'h10;
			vec_sel = `IOC_VEC_SERIAL;
		end else begin
			grant = 6'h20;
			vec_sel = `IOC_VEC_MULTI;
		end
	end
	assign wr_fire = wr_aw_reg & wr_w_reg & ~s_axi_bvalid;
	always @* begin
		pri_next = pri_reg;
		sec_next = sec_reg;
		mf_next = mf_reg;
		if (wr_fire) begin
			case (wr_addr_reg)
			`IOC_OFS_PRIMARY: pri_next = wr_data_reg[6:0];
			`IOC_OFS_SECONDARY: sec_next = wr_data_reg[6:0];
			`IOC_OFS_MULTI: mf_next = wr_data_reg[6:0];
			default: begin
			end
			endcase
		end
		if (take) begin
			pri_next[`IOC_BIT_MASTER] = 1'b0;
			pri_next[6:4] = pri_next[6:4] & ~grant[2:0];
			sec_next[6:4] = sec_next[6:4] & ~grant[5:3];
		end else if (return_from_irq) begin
			pri_next[`IOC_BIT_MASTER] = 1'b1;
		end
		// Hardware sets win over clears in the same cycle
		pri_next[6:4] = pri_next[6:4] | ev_rise[2:0];
		sec_next[5:4] = sec_next[5:4] | ev_rise[4:3];
		mf_next[4] = mf_next[4] | ev_rise[5];
		mf_next[5] = mf_next[5] | ev_rise[6];
		mf_next[6] = mf_next[6] | ev_rise[7];
		sec_next[6] = sec_next[6] | (|ev_rise[7:5]);
		pri_next[3] = pri_next[3];
		sec_next[3] = 1'b0;
		mf_next[3] = 1'b0;
	end
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`IOC_OFS_PRIMARY: rd_byte = {1'b0, pri_reg};
		`IOC_OFS_SECONDARY: rd_byte = {1'b0, sec_reg};
		`IOC_OFS_MULTI: rd_byte = {1'b0, mf_reg};
		`IOC_OFS_CLKCTL: rd_byte = {3'h0, quick_reg, 4'h0};
		`IOC_OFS_STATUS: rd_byte = {4'h0, pd_s, wdt_off_s, src_reg};
		default: begin
			rd_byte = 8'h00;
			rd_ok = 1'b0;
		end
		endcase
	end
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pri_reg <= 7'h00;
			sec_reg <= 7'h00;
			mf_reg <= 7'h00;
			quick_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IOC_RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IOC_RESP_OK;
			wr_aw_reg <= 1'b0;
			wr_w_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			irq_vector_valid <= 1'b0;
			irq_vector <= 8'h00;
		end else begin
			pri_reg <= pri_next;
			sec_reg <= sec_next;
			mf_reg <= mf_next;
			irq_vector_valid <= take;
			if (take)
				irq_vector <= vec_sel;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			if (s_axi_awvalid && !wr_aw_reg && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				wr_aw_reg <= 1'b1;
				wr_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !wr_w_reg && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				wr_w_reg <= 1'b1;
				wr_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (wr_fire) begin
				wr_aw_reg <= 1'b0;
				wr_w_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_addr_reg == `IOC_OFS_CLKCTL)
					quick_reg <= wr_data_reg[`IOC_BIT_QUICK];
				case (wr_addr_reg)
				`IOC_OFS_PRIMARY, `IOC_OFS_SECONDARY, `IOC_OFS_MULTI, `IOC_OFS_CLKCTL,
				`IOC_OFS_STATUS: s_axi_bresp <= `IOC_RESP_OK;
				default: s_axi_bresp <= `IOC_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_ok ? `IOC_RESP_OK : `IOC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// Clock steering; the analog oscillators follow these enables
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= 2'h0;
			sys_osc_enable <= 1'b1;
			exec_halt <= 1'b0;
			ext_inputs_gate <= 1'b0;
			timing_run <= 1'b1;
			clock_osc_enable <= 1'b1;
			clock_osc_quick <= 1'b0;
			wdt_osc_enable <= 1'b0;
			osc_out_pin <= 1'b0;
			osc_out_pin_oe <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			sys_osc_enable <= !(pd_s && src_reg != `IOC_SRC_32K);
			exec_halt <= pd_s;
			ext_inputs_gate <= pd_s && src_reg != `IOC_SRC_32K;
			timing_run <= !pd_s || src_reg == `IOC_SRC_32K;
			clock_osc_enable <= 1'b1;
			clock_osc_quick <= quick_reg;
			wdt_osc_enable <= !wdt_off_s;
			osc_out_pin <= div_reg[1];
			osc_out_pin_oe <= src_reg == `IOC_SRC_RC && !pd_s;
		end
	end
endmodule // ioc_irq_osc_ctrl
`default_nettype wire

/* tb/ioc_properties.sv */
// Port-level assertions for the interrupt and oscillator control block
`timescale 1ns/1ps
`default_nettype none
module ioc_props (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [1:0] clk_source_sel,
	input wire logic wdt_osc_disable,
	input wire logic power_down,
	input wire logic stack_full,
	input wire logic instr_boundary,
	input wire logic irq_vector_valid,
	input wire logic [7:0] irq_vector,
	input wire logic sys_osc_enable,
	input wire logic exec_halt,
	input wire logic timing_run,
	input wire logic wdt_osc_enable,
	input wire logic osc_out_pin,
	input wire logic osc_out_pin_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence div_high_s;
		osc_out_pin ##1 !osc_out_pin;
	endsequence
	sequence pd_fast_s;
		(power_down && clk_source_sel != 2'h2)[*6];
	endsequence
	AST_VEC_ONE: assert property (irq_vector_valid |=> !irq_vector_valid)
		else $error("vector pulse too long");
	AST_VEC_CAUSE: assert property (irq_vector_valid |-> $past(instr_boundary) && !$past(stack_full))
		else $error("vector without boundary or with full stack");
	AST_VEC_CODE: assert property (irq_vector_valid |-> irq_vector inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18})
		else $error("illegal vector");
	AST_WDT_OFF: assert property (wdt_osc_disable[*6] |-> !wdt_osc_enable)
		else $error("watchdog osc not disabled");
	AST_WDT_RUN: assert property ((!wdt_osc_disable && power_down)[*6] |-> wdt_osc_enable)
		else $error("watchdog osc stopped in power down");
	AST_DIV4: assert property ($rose(osc_out_pin) && osc_out_pin_oe |=> div_high_s)
		else $error("clock out not divided by four");
	AST_PD_STOP: assert property (pd_fast_s |-> !sys_osc_enable && !osc_out_pin_oe)
		else $error("system osc runs in power down");
	AST_PD_SLOW: assert property ((power_down && clk_source_sel == 2'h2)[*6] |-> sys_osc_enable && exec_halt && timing_run)
		else $error("low speed source power down wrong");
endmodule // ioc_props
`default_nettype wire

/* tb/ioc_core_model.sv */
// Core sequencer model: instruction boundaries, stack state, returns
`timescale 1ns/1ps
`default_nettype none
module ioc_core_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic irq_vector_valid,
	input wire logic [7:0] irq_vector,
	input wire logic hold_full,
	input wire logic rti_cmd,
	output logic instr_boundary,
	output logic stack_full,
	output var logic return_from_irq,
	output var logic [7:0] last_vec,
	output var logic [7:0] vec_count
);
	logic [1:0] phase_reg;
	// One instruction every four clocks
	assign instr_boundary = phase_reg == 2'h3;
	assign stack_full = hold_full;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= 2'h0;
			return_from_irq <= 1'b0;
			last_vec <= 8'h00;
			vec_count <= 8'h00;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			return_from_irq <= rti_cmd;
			if (irq_vector_valid) begin
				last_vec <= irq_vector;
				vec_count <= vec_count + 8'h01;
			end
		end
	end
endmodule // ioc_core_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the interrupt and oscillator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock = 1'b0, rst_b = 1'b0, hold_full = 1'b0, rti_cmd = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ev = 8'h00, vc_seen = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, clk_source_sel = 2'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic wdt_osc_disable = 1'b0, power_down = 1'b0, stack_full, instr_boundary, return_from_irq;
	logic irq_vector_valid, sys_osc_enable, exec_halt, ext_inputs_gate, timing_run, clock_osc_enable;
	logic clock_osc_quick, wdt_osc_enable, osc_out_pin, osc_out_pin_oe;
	logic [7:0] irq_vector, last_vec, vec_count;
	logic [7:0] vt [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	wire ext0_event, ext1_event, timer0_event, timer1_event, serial_event, timer2_event, tick_event, clock_timeout_event;
	int err_total = 0, checks = 0;
	assign {clock_timeout_event, tick_event, timer2_event, serial_event, timer1_event, timer0_event, ext1_event, ext0_event} = ev;
	ioc_irq_osc_ctrl ioc_irq_osc_ctrl_inst (.*);
	ioc_core_model ioc_core_model_inst (.*);
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
		chk(d, {24'h000000, e}, $sformatf("register %h", a));
	endtask
	task automatic vec(input logic [7:0] e);
		int n;
		n = 0;
		while (vec_count === vc_seen && n < 200) begin
			@(posedge clock);
			n++;
		end
		vc_seen = vec_count;
		chk(last_vec, e, "vector");
	endtask
	task automatic idle;
		repeat (30) @(posedge clock);
		chk(vec_count, vc_seen, "vector count");
	endtask
	task automatic rti;
		rti_cmd <= 1'b1;
		@(posedge clock);
		rti_cmd <= 1'b0;
		@(posedge clock);
	endtask
	task automatic pulse(input logic [7:0] m);
		ev <= m;
		repeat (2) @(posedge clock);
		ev <= 8'h00;
		repeat (6) @(posedge clock);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rchk(8'h2C, 8'h00);
		rchk(8'h78, 8'h00);
		rchk(8'hBC, 8'h00);
		rchk(8'h10, 8'h00);
		chk(r, 2'h2, "unmapped response");
		wr(8'h10, 8'h00);
		chk(r, 2'h2, "unmapped write response");
		wr(8'h2C, 8'h00);
		chk(r, 2'h0, "write response");
		pulse(8'hFF);
		rchk(8'h2C, 8'h70);
		rchk(8'h78, 8'h70);
		rchk(8'hBC, 8'h70);
		wr(8'h2C, 8'h7E);
		wr(8'h78, 8'hFF);
		wr(8'hBC, 8'hFF);
		rchk(8'h78, 8'h77);
		rchk(8'hBC, 8'h77);
		idle();
		wr(8'h2C, 8'h7F);
		foreach (vt[i]) begin
			vec(vt[i]);
			idle();
			rti();
		end
		rchk(8'h2C, 8'h0F);
		rchk(8'h78, 8'h07);
		rchk(8'hBC, 8'h77);
		$display("test priority finished");
		wr(8'hBC, 8'h07);
		wr(8'h78, 8'h03);
		pulse(8'h20);
		idle();
		rchk(8'h78, 8'h43);
		hold_full <= 1'b1;
		wr(8'h78, 8'h47);
		idle();
		hold_full <= 1'b0;
		vec(8'h18);
		$display("test masking finished");
		wr(8'hC0, 8'h10);
		repeat (2) @(posedge clock);
		chk(clock_osc_quick, 1'b1, "quick start");
		power_down <= 1'b1;
		repeat (10) @(posedge clock);
		chk(sys_osc_enable, 1'b0, "system osc");
		chk(ext_inputs_gate, 1'b1, "inputs gated");
		chk(wdt_osc_enable, 1'b1, "watchdog osc");
		power_down <= 1'b0;
		wdt_osc_disable <= 1'b1;
		repeat (10) @(posedge clock);
		chk(wdt_osc_enable, 1'b0, "watchdog off");
		wdt_osc_disable <= 1'b0;
		rst_b <= 1'b0;
		clk_source_sel <= 2'h2;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		rchk(8'hC4, 8'h02);
		power_down <= 1'b1;
		repeat (10) @(posedge clock);
		chk(exec_halt, 1'b1, "halt");
		chk(sys_osc_enable & timing_run & clock_osc_enable, 1'b1, "slow run");
		$display("test oscillators finished");
		end_sim();
	end
endmodule // testbench
bind ioc_irq_osc_ctrl ioc_props ioc_props_inst (.*);
`default_nettype wire
